// ==== core/can_filter_pkg.sv ====
// shared constants for the can acceptance filter and interrupt block
package can_filter_pkg;
  localparam int NUM_CENTERS = 15;
  localparam int IDX_W = 4;
  localparam int ID_W = 29;
  localparam int STD_W = 11;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] ADDR_CAN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
  localparam logic [7:0] ADDR_STD_MASK = 8'h10;
  localparam logic [7:0] ADDR_EXT_MASK = 8'h14;
  localparam logic [7:0] ADDR_M15_MASK = 8'h18;
  localparam logic [7:0] ADDR_MEDIA_ARB = 8'h1C;
  localparam logic [7:0] ADDR_MEDIA_MASK = 8'h20;
  localparam logic [7:0] ADDR_RX_RESULT = 8'h24;
  localparam logic [7:0] ADDR_TX_SELECT = 8'h28;
  localparam logic [7:0] ADDR_CENTER_BASE = 8'h40;
  localparam logic [7:0] ADDR_CENTER_END = 8'hB4;
  // per-center block: 8 bytes each, word 0 arbitration, word 1 control/format
  localparam int CENTER_SHIFT = 3;
  localparam logic [2:0] CENTER_WORD_ARB = 3'h0;
  localparam logic [2:0] CENTER_WORD_CTL = 3'h4;
  // can control register bits
  localparam int CTRL_ERROR_IE = 0;
  localparam int CTRL_STATUS_IE = 1;
  localparam int CTRL_GLOBAL_IE = 7;
  localparam int CTRL_CAN_IE = 6;
  // center control/format word bits
  localparam int CC_READY = 0;
  localparam int CC_TX_IE = 1;
  localparam int CC_RX_IE = 2;
  localparam int CC_REQ = 3;
  localparam int CC_UPDATED = 4;
  localparam int CC_OVERRUN = 5;
  localparam int CC_MEDIA_EN = 8;
  localparam int CC_MASK_EN = 9;
  localparam int CC_FORMAT = 10;
  localparam int CC_DIR_TX = 11;
  localparam int CC_LEN_LSB = 12;
  localparam int CC_OVERWRITE = 16;
  // irq status bits
  localparam int ST_ERROR = 0;
  localparam int ST_STATUS = 1;
  localparam int ST_RX_DROP = 2;
  localparam logic [7:0] STATUS_W = 8'h03;
  localparam logic [3:0] MAX_LEN = 4'h8;
endpackage

// ==== core/can_accept_filter.sv ====
// acceptance filter, message center flags and interrupt combiner
// Operation
// - tx or rx success sets center request when its irq enable is set
// - center request stays set until software clears it
// - can interrupt is OR of all center requests and enabled conditions
// - cpu sees interrupt only with global and can enables both set
// - error and status interrupts gated by their own enables
// - acceptance test starts only for frames free of bit errors
// - ready centers tested 1 to 15, first pass wins
// - 11 or 29 id bits compared per format select
// - mask enable 0 exact match, 1 compare global mask bits only
// - media enable compares data bytes 1 and 2 under media mask
// - center 15 mask ANDed with global mask when masking enabled
// - frame loaded only if id and enabled media tests pass
// - format register holds direction and length 0 to 8
// - center 15 is receive only
// - after lost arbitration or error reload lowest pending tx center
// - unread center drops frame unless overwrite enable, then flag overrun
// - center 15 buffers one extra unread message until flags cleared
`timescale 1ns/1ps
module can_accept_filter (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // protocol engine events
  input wire logic frame_valid_i,
  input wire logic frame_bit_error_i,
  input wire logic frame_ext_i,
  input wire logic [28:0] frame_id_i,
  input wire logic [7:0] frame_data1_i,
  input wire logic [7:0] frame_data2_i,
  input wire logic tx_done_i,
  input wire logic [3:0] tx_done_center_i,
  input wire logic tx_retry_i,
  input wire logic error_event_i,
  input wire logic status_event_i,
  // outputs
  output logic accept_o,
  output logic [3:0] accept_center_o,
  output logic tx_load_o,
  output logic [3:0] tx_center_o,
  output logic irq_o
);
  localparam int N = can_filter_pkg::NUM_CENTERS;
  // n is fixed at fifteen; the buffered center is always the last index

  // software visible state; the per-center words are kept as arrays
  // so one loop can scan them, at the cost of a wide read mux
  // register map and bit positions live in the package
  logic [7:0] can_ctrl, next_can_ctrl;
  logic [2:0] irq_status, next_irq_status;
  logic [2:0] irq_enable, next_irq_enable;
  logic [28:0] std_mask, next_std_mask;
  logic [28:0] ext_mask, next_ext_mask;
  logic [28:0] m15_mask, next_m15_mask;
  logic [15:0] media_arb, next_media_arb;
  logic [15:0] media_mask, next_media_mask;
  logic [28:0] arb [N];
  logic [28:0] next_arb [N];
  logic [16:0] center_control_reg [N];
  logic [16:0] next_center_control_reg [N];
  logic m15_buf_full, next_m15_buf_full;
  // next values of the output flops
  logic [31:0] next_rdata;
  logic next_accept;
  logic [3:0] next_accept_center;
  logic next_tx_load;
  logic [3:0] next_tx_center;
  logic next_irq;

  // event strobes come from the protocol engine on this clock,
  // so they are read directly with no synchroniser
  // scan results: pass per center, first hit, first pending transmit
  // a hit is only a candidate; the unread and overwrite checks below
  // still decide whether the frame is stored
  logic [N-1:0] pass;
  logic hit;
  logic [3:0] hit_idx;
  logic [3:0] pend_idx;
  logic pend_any;

  // hazard: the id and mask paths are combinational from the frame inputs,
  // so frame fields must be settled in the cycle frame_valid_i is high
  // a center whose format differs from the frame never passes, even
  // when its mask would hide every compared bit
  // per-center identifier and media test
  always_comb begin
    logic [28:0] m;
    logic [28:0] cmp;
    logic id_ok;
    logic media_ok;
    m = '0;
    cmp = '0;
    id_ok = 1'b0;
    media_ok = 1'b0;
    for (int i = 0; i < N; i++) begin
      cmp = center_control_reg[i][can_filter_pkg::CC_FORMAT] ? {29{1'b1}} : {{18{1'b0}}, {11{1'b1}}};
      m = cmp;
      if (center_control_reg[i][can_filter_pkg::CC_MASK_EN]) begin
        m = cmp & (center_control_reg[i][can_filter_pkg::CC_FORMAT] ? ext_mask : std_mask);
        if (i == N - 1) begin
          m = m & m15_mask;
        end
      end
      id_ok = ((frame_id_i ^ arb[i]) & m) == '0 &&
              (center_control_reg[i][can_filter_pkg::CC_FORMAT] == frame_ext_i);
      // media bytes pair data1 high and data2 low against the media arbitration value
      // media bytes under media mask
      media_ok = !center_control_reg[i][can_filter_pkg::CC_MEDIA_EN] ||
                 ((({frame_data1_i, frame_data2_i} ^ media_arb) & media_mask) == '0);
      // both tests, receive centers that are ready
      pass[i] = id_ok && media_ok && center_control_reg[i][can_filter_pkg::CC_READY] &&
                !center_control_reg[i][can_filter_pkg::CC_DIR_TX];
    end
  end

  // scanning downward lets the lowest index overwrite the result last,
  // which gives ascending priority without a separate encoder
  // first passing center in ascending order
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    pend_any = 1'b0;
    pend_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pass[i]) begin
        hit = 1'b1;
        hit_idx = 4'(i);
      end
      // pending means ready, transmit direction and no request yet;
      // a finished message with its tx irq enable gets its request set and drops out of the scan
      // lowest numbered pending transmit
      if (center_control_reg[i][can_filter_pkg::CC_READY] && center_control_reg[i][can_filter_pkg::CC_DIR_TX] &&
          !center_control_reg[i][can_filter_pkg::CC_REQ]) begin
        pend_any = 1'b1;
        pend_idx = 4'(i);
      end
    end
  end

  // one combinational process owns every next value so the set-wins
  // ordering between software writes and hardware events is explicit:
  // writes are applied first, hardware sets after them
  // next state for registers, flags and outputs
  always_comb begin
    logic [3:0] ci;
    logic hit_here;
    logic unread;
    logic wr_ctl;
    next_can_ctrl = can_ctrl;
    next_irq_status = irq_status;
    next_irq_enable = irq_enable;
    next_std_mask = std_mask;
    next_ext_mask = ext_mask;
    next_m15_mask = m15_mask;
    next_media_arb = media_arb;
    next_media_mask = media_mask;
    next_m15_buf_full = m15_buf_full;
    next_accept = 1'b0;
    next_accept_center = accept_center_o;
    next_tx_load = 1'b0;
    next_tx_center = tx_center_o;
    next_rdata = '0;
    // center index from the byte address; only 0x40 to 0xB4 is decoded,
    // so the wrap of the 4-bit subtract never reaches a slot past 14
    ci = addr_i[6:3] - 4'h8;
    hit_here = 1'b0;
    unread = 1'b0;
    wr_ctl = 1'b0;
    for (int i = 0; i < N; i++) begin
      next_arb[i] = arb[i];
      next_center_control_reg[i] = center_control_reg[i];
    end
    // request bits change only by software writes or hardware sets
    // software writes
    if (wr_i) begin
      case (addr_i)
        can_filter_pkg::ADDR_CAN_CTRL: next_can_ctrl = wdata_i[7:0];
        can_filter_pkg::ADDR_IRQ_ENABLE: next_irq_enable = wdata_i[2:0];
        can_filter_pkg::ADDR_IRQ_CLEAR: next_irq_status = irq_status & ~wdata_i[2:0];
        // the four acceptance masks and the media arbitration value are software written
        can_filter_pkg::ADDR_STD_MASK: next_std_mask = {18'h0, wdata_i[10:0]};
        can_filter_pkg::ADDR_EXT_MASK: next_ext_mask = wdata_i[28:0];
        can_filter_pkg::ADDR_M15_MASK: next_m15_mask = wdata_i[28:0];
        can_filter_pkg::ADDR_MEDIA_ARB: next_media_arb = wdata_i[15:0];
        can_filter_pkg::ADDR_MEDIA_MASK: next_media_mask = wdata_i[15:0];
        default: begin
          if (addr_i >= can_filter_pkg::ADDR_CENTER_BASE && addr_i <= can_filter_pkg::ADDR_CENTER_END) begin
            if (addr_i[2:0] == can_filter_pkg::CENTER_WORD_ARB) begin
              next_arb[ci] = wdata_i[28:0];
            end else if (addr_i[2:0] == can_filter_pkg::CENTER_WORD_CTL) begin
              wr_ctl = 1'b1;
              next_center_control_reg[ci] = wdata_i[16:0];
              // long lengths are clamped rather than refused, so reads show 8
              // length clamps to 8
              if (wdata_i[15:12] > can_filter_pkg::MAX_LEN) begin
                next_center_control_reg[ci][15:12] = can_filter_pkg::MAX_LEN;
              end
              if (ci == 4'(N - 1)) begin
                next_center_control_reg[ci][can_filter_pkg::CC_DIR_TX] = 1'b0;
              end
              // the buffer here is only occupancy; frame data lives in the
              // message store outside this block
              // buffered frame moves in once updated and request are cleared
              if (ci == 4'(N - 1) && m15_buf_full && !wdata_i[can_filter_pkg::CC_UPDATED] &&
                  !wdata_i[can_filter_pkg::CC_REQ]) begin
                next_center_control_reg[ci][can_filter_pkg::CC_UPDATED] = 1'b1;
                next_center_control_reg[ci][can_filter_pkg::CC_REQ] =
                  center_control_reg[ci][can_filter_pkg::CC_RX_IE];
                next_m15_buf_full = 1'b0;
              end
            end
          end
        end
      endcase
    end
    // frame acceptance: a hit is stored, buffered in center 15, or dropped
    // dropped frames raise the rx drop status bit so software sees loss
    // one frame per cycle at most; the engine never sends two
    // only error-free frames reach the filter
    if (frame_valid_i && !frame_bit_error_i && hit) begin
      hit_here = 1'b1;
      unread = center_control_reg[hit_idx][can_filter_pkg::CC_UPDATED];
      if (hit_idx == 4'(N - 1) && unread && !m15_buf_full) begin
        next_m15_buf_full = 1'b1;
        next_accept = 1'b1;
        next_accept_center = hit_idx;
      end else if (unread && !center_control_reg[hit_idx][can_filter_pkg::CC_OVERWRITE]) begin
        next_irq_status[can_filter_pkg::ST_RX_DROP] = 1'b1;
      end else begin
        next_accept = 1'b1;
        next_accept_center = hit_idx;
        if (!(hit_idx == 4'(N - 1) && m15_buf_full)) begin
          next_center_control_reg[hit_idx][can_filter_pkg::CC_UPDATED] = 1'b1;
        end
        if (unread) begin
          next_center_control_reg[hit_idx][can_filter_pkg::CC_OVERRUN] = 1'b1;
        end
        // receive request, set wins over clear
        if (center_control_reg[hit_idx][can_filter_pkg::CC_RX_IE]) begin
          next_center_control_reg[hit_idx][can_filter_pkg::CC_REQ] = 1'b1;
        end
      end
    end
    // transmit outcome; center numbers outside 1 to 15 are ignored
    // transmit request, set wins over a same-cycle clear
    if (tx_done_i && tx_done_center_i >= 4'h1 && tx_done_center_i <= 4'(N)) begin
      if (center_control_reg[tx_done_center_i - 4'h1][can_filter_pkg::CC_TX_IE]) begin
        next_center_control_reg[tx_done_center_i - 4'h1][can_filter_pkg::CC_REQ] = 1'b1;
      end
    end
    if (tx_retry_i && pend_any) begin
      next_tx_load = 1'b1;
      next_tx_center = pend_idx + 4'h1;
    end
    if (error_event_i) begin
      next_irq_status[can_filter_pkg::ST_ERROR] = 1'b1;
    end
    if (status_event_i) begin
      next_irq_status[can_filter_pkg::ST_STATUS] = 1'b1;
    end
    // the level is built from next values so irq_o follows its cause
    // one edge later, matching the other registered outputs
    // combine center requests and enabled conditions
    next_irq = 1'b0;
    for (int i = 0; i < N; i++) begin
      next_irq = next_irq | next_center_control_reg[i][can_filter_pkg::CC_REQ];
    end
    next_irq = next_irq ||
      (next_irq_status[can_filter_pkg::ST_ERROR] && next_can_ctrl[can_filter_pkg::CTRL_ERROR_IE]) ||
      (next_irq_status[can_filter_pkg::ST_STATUS] && next_can_ctrl[can_filter_pkg::CTRL_STATUS_IE]) ||
      (|(next_irq_status & next_irq_enable));
    // global and can enables both required
    next_irq = next_irq && next_can_ctrl[can_filter_pkg::CTRL_GLOBAL_IE] &&
               next_can_ctrl[can_filter_pkg::CTRL_CAN_IE];
    // reads, data one cycle later, unmapped reads zero
    // limitation: reads see the state before this edge, so a read in the
    // same cycle as an event returns the older value
    // write-only and unmapped addresses read as zero
    if (rd_i) begin
      case (addr_i)
        can_filter_pkg::ADDR_CAN_CTRL: next_rdata = {24'h0, can_ctrl};
        can_filter_pkg::ADDR_IRQ_STATUS: next_rdata = {29'h0, irq_status};
        can_filter_pkg::ADDR_IRQ_ENABLE: next_rdata = {29'h0, irq_enable};
        can_filter_pkg::ADDR_STD_MASK: next_rdata = {3'h0, std_mask};
        can_filter_pkg::ADDR_EXT_MASK: next_rdata = {3'h0, ext_mask};
        can_filter_pkg::ADDR_M15_MASK: next_rdata = {3'h0, m15_mask};
        can_filter_pkg::ADDR_MEDIA_ARB: next_rdata = {16'h0, media_arb};
        can_filter_pkg::ADDR_MEDIA_MASK: next_rdata = {16'h0, media_mask};
        can_filter_pkg::ADDR_RX_RESULT: next_rdata = {27'h0, m15_buf_full, accept_center_o};
        can_filter_pkg::ADDR_TX_SELECT: next_rdata = {28'h0, tx_center_o};
        default: begin
          if (addr_i >= can_filter_pkg::ADDR_CENTER_BASE && addr_i <= can_filter_pkg::ADDR_CENTER_END) begin
            if (addr_i[2:0] == can_filter_pkg::CENTER_WORD_ARB) begin
              next_rdata = {3'h0, arb[ci]};
            end else if (addr_i[2:0] == can_filter_pkg::CENTER_WORD_CTL) begin
              next_rdata = {15'h0, center_control_reg[ci]};
            end
          end
        end
      endcase
    end
  end

  // plain register stage; every output comes straight from a flop
  // all centers reset disabled, so no frame is taken until software
  // sets a ready bit
  // register everything; reset to idle, all centers disabled
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      can_ctrl <= 8'h00;
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      std_mask <= 29'h0;
      ext_mask <= 29'h0;
      m15_mask <= 29'h0;
      media_arb <= 16'h0;
      media_mask <= 16'h0;
      m15_buf_full <= 1'b0;
      rdata_o <= 32'h0;
      accept_o <= 1'b0;
      accept_center_o <= 4'h0;
      tx_load_o <= 1'b0;
      tx_center_o <= 4'h0;
      irq_o <= 1'b0;
      for (int i = 0; i < N; i++) begin
        arb[i] <= 29'h0;
        center_control_reg[i] <= 17'h0;
      end
    end else begin
      can_ctrl <= next_can_ctrl;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      std_mask <= next_std_mask;
      ext_mask <= next_ext_mask;
      m15_mask <= next_m15_mask;
      media_arb <= next_media_arb;
      media_mask <= next_media_mask;
      m15_buf_full <= next_m15_buf_full;
      rdata_o <= next_rdata;
      accept_o <= next_accept;
      accept_center_o <= next_accept_center;
      tx_load_o <= next_tx_load;
      tx_center_o <= next_tx_center;
      irq_o <= next_irq;
      for (int i = 0; i < N; i++) begin
        arb[i] <= next_arb[i];
        center_control_reg[i] <= next_center_control_reg[i];
      end
    end
  end
endmodule

// ==== sim/can_node_model.sv ====
// model of the other bus nodes: received frames and transmit outcomes
`timescale 1ns/1ps
module can_node_model (
  // clock
  input wire logic core_clk_i,
  // frame outcome lines
  output logic frame_valid_o,
  output logic frame_bit_error_o,
  output logic frame_ext_o,
  output logic [28:0] frame_id_o,
  output logic [7:0] frame_data1_o,
  output logic [7:0] frame_data2_o,
  // transmit outcome lines
  output logic tx_done_o,
  output logic [3:0] tx_done_center_o,
  output logic tx_retry_o
);
  // idle values at time zero
  initial begin
    {frame_valid_o, frame_bit_error_o, frame_ext_o, tx_done_o, tx_retry_o} = 5'h00;
    {frame_id_o, frame_data1_o, frame_data2_o, tx_done_center_o} = 49'h0;
  end
  // one frame; fields are stale after the pulse, so all but the format bit are scrambled
  task automatic send(input logic x, input logic [28:0] id, input logic [15:0] d, input logic e);
    @(posedge core_clk_i);
    frame_valid_o <= 1'b1;
    frame_bit_error_o <= e;
    frame_ext_o <= x;
    frame_id_o <= id;
    {frame_data1_o, frame_data2_o} <= d;
    @(posedge core_clk_i);
    frame_valid_o <= 1'b0;
    frame_bit_error_o <= ~e;
    frame_id_o <= ~id;
    {frame_data1_o, frame_data2_o} <= ~d;
  endtask
  // transmit success (c high) or lost arbitration (c zero)
  task automatic tx(input logic [3:0] c);
    @(posedge core_clk_i);
    tx_done_o <= (c != 4'h0);
    tx_retry_o <= (c == 4'h0);
    tx_done_center_o <= c;
    @(posedge core_clk_i);
    {tx_done_o, tx_retry_o} <= 2'h0;
    tx_done_center_o <= ~c;
  endtask
endmodule

// ==== sim/can_accept_filter_chk.sv ====
// port checker for the acceptance filter
`timescale 1ns/1ps
module can_accept_filter_chk (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // events
  input wire logic frame_valid_i,
  input wire logic frame_bit_error_i,
  input wire logic tx_retry_i,
  input wire logic error_event_i,
  // outputs
  input wire logic accept_o,
  input wire logic [3:0] accept_center_o,
  input wire logic tx_load_o,
  input wire logic [3:0] tx_center_o,
  input wire logic irq_o
);
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  // shadow of the control word, the irq gates live there
  always_comb begin
    next_ctrl = ctrl;
    if (wr_i && addr_i == can_filter_pkg::ADDR_CAN_CTRL) begin
      next_ctrl = wdata_i;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_err_frame_drop: assert property (frame_valid_i && frame_bit_error_i |=> !accept_o)
    else $error("accept after bit error frame");
  a_accept_cause: assert property (accept_o |-> $past(frame_valid_i && !frame_bit_error_i))
    else $error("accept without clean frame");
  a_center_range: assert property (accept_o |-> accept_center_o < 4'hF)
    else $error("accept center out of range");
  a_center_holds: assert property (!accept_o |-> $stable(accept_center_o))
    else $error("accept center moved without accept");
  a_load_cause: assert property (tx_load_o |-> $past(tx_retry_i))
    else $error("tx load without retry");
  a_no_tx_last: assert property (tx_load_o |-> tx_center_o inside {[1:14]})
    else $error("tx load of receive only center");
  a_irq_gated: assert property (irq_o |-> ctrl[7] && ctrl[6])
    else $error("irq without global and can enable");
  a_error_irq: assert property (error_event_i && ctrl[7:6] == 2'h3 && ctrl[0] |-> ##[1:2] irq_o)
    else $error("enabled error event gave no irq");
  a_irq_sticky: assert property (irq_o && !wr_i && !$past(wr_i) |=> irq_o)
    else $error("irq dropped without software write");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  c_accept: cover property (accept_o);
  c_tx_load: cover property (tx_load_o);
  c_irq: cover property ($rose(irq_o));
endmodule
bind can_accept_filter can_accept_filter_chk i_can_accept_filter_chk (
  .core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .frame_valid_i,
  .frame_bit_error_i, .tx_retry_i, .error_event_i, .accept_o, .accept_center_o,
  .tx_load_o, .tx_center_o, .irq_o
);

// ==== sim/can_accept_filter_bench.sv ====
// self-checking bench for the acceptance filter
`timescale 1ns/1ps
module can_accept_filter_bench;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic error_event_i = 1'b0;
  logic status_event_i = 1'b0;
  logic fv, fe, fx, td, tr, accept_o, tx_load_o, irq_o;
  logic [28:0] fid;
  logic [7:0] d1, d2;
  logic [3:0] tdc, accept_center_o, tx_center_o;
  logic [31:0] rdata_o, v;
  int fail_count = 0;
  int tests_run = 0;
  // 100 MHz core clock
  always #5 core_clk_i = ~core_clk_i;
  can_accept_filter i_can_accept_filter (
    .core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .frame_valid_i(fv), .frame_bit_error_i(fe), .frame_ext_i(fx), .frame_id_i(fid),
    .frame_data1_i(d1), .frame_data2_i(d2), .tx_done_i(td), .tx_done_center_i(tdc),
    .tx_retry_i(tr), .error_event_i, .status_event_i, .accept_o, .accept_center_o,
    .tx_load_o, .tx_center_o, .irq_o
  );
  can_node_model i_can_node_model (
    .core_clk_i, .frame_valid_o(fv), .frame_bit_error_o(fe), .frame_ext_o(fx),
    .frame_id_o(fid), .frame_data1_o(d1), .frame_data2_o(d2), .tx_done_o(td),
    .tx_done_center_o(tdc), .tx_retry_o(tr)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  function automatic logic [7:0] ca(input int i, input int w);
    return 8'(8'h40 + 8 * i + w);
  endfunction
  // frame in, then accept pulse and winning center
  task automatic fr(input logic x, input logic [28:0] id, input logic [15:0] d, input logic e,
                    input logic acc, input logic [3:0] c);
    i_can_node_model.send(x, id, d, e);
    #1 chk(accept_o, acc);
    if (acc) begin
      chk(accept_center_o, c);
    end
  endtask
  // irq is a registered level, give the cause two edges
  task automatic irq(input logic exp);
    repeat (2) @(posedge core_clk_i);
    #1 chk(irq_o, exp);
  endtask
  task automatic ev(input logic s);
    @(posedge core_clk_i);
    error_event_i <= !s;
    status_event_i <= s;
    @(posedge core_clk_i);
    {error_event_i, status_event_i} <= 2'h0;
  endtask
  task automatic results();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(8'h00);
    chk(v, 32'h0);
    rd(8'h30);
    chk(v, 32'h0);
    // masks, then centers 1, 2, 3, 4, 6 and 15
    wr(8'h10, 32'h700);
    wr(8'h14, 32'hFFFF);
    wr(8'h18, 32'h1FFF0000);
    wr(8'h1C, 32'h1234);
    wr(8'h20, 32'hFFFF);
    wr(ca(0, 0), 32'h555);
    wr(ca(0, 4), 32'h200);
    wr(ca(1, 0), 32'h1ABCDEF0);
    wr(ca(1, 4), 32'h501);
    wr(ca(2, 0), 32'h523);
    wr(ca(2, 4), 32'h5);
    wr(ca(14, 4), 32'hE01);
    rd(ca(14, 4));
    chk(v, 32'h601);
    wr(ca(3, 4), 32'hF803);
    rd(ca(3, 4));
    chk(v, 32'h8803);
    wr(ca(5, 4), 32'h8801);
    fr(1'b0, 29'h523, 16'h0, 1'b1, 1'b0, 4'h0);
    fr(1'b0, 29'h523, 16'h0, 1'b0, 1'b1, 4'h2);
    wr(ca(0, 4), 32'h201);
    fr(1'b0, 29'h523, 16'h0, 1'b0, 1'b1, 4'h0);
    fr(1'b0, 29'h5AA, 16'h0, 1'b0, 1'b0, 4'h0);
    rd(8'h04);
    chk(v, 32'h4);
    fr(1'b1, 29'h1ABCDEF0, 16'h1235, 1'b0, 1'b1, 4'hE);
    fr(1'b1, 29'h1ABCDEF0, 16'h1234, 1'b0, 1'b1, 4'h1);
    fr(1'b1, 29'h1ABCDEF0, 16'h1235, 1'b0, 1'b1, 4'hE);
    rd(8'h24);
    chk(v, 32'h1E);
    wr(ca(14, 4), 32'hE01);
    rd(ca(14, 4));
    chk(v, 32'h611);
    wr(ca(0, 4), 32'h10211);
    fr(1'b0, 29'h5AA, 16'h0, 1'b0, 1'b1, 4'h0);
    rd(ca(0, 4));
    chk(v, 32'h10231);
    // center 3 request is pending from its receive
    irq(1'b0);
    wr(8'h00, 32'hC0);
    irq(1'b1);
    repeat (5) @(posedge core_clk_i);
    irq(1'b1);
    wr(ca(2, 4), 32'h5);
    irq(1'b0);
    ev(1'b0);
    irq(1'b0);
    wr(8'h00, 32'hC1);
    irq(1'b1);
    wr(8'h0C, 32'h7);
    wr(8'h00, 32'hC2);
    irq(1'b0);
    ev(1'b1);
    irq(1'b1);
    wr(8'h00, 32'h42);
    irq(1'b0);
    wr(8'h00, 32'hC0);
    irq(1'b0);
    wr(8'h08, 32'h2);
    irq(1'b1);
    wr(8'h0C, 32'h7);
    irq(1'b0);
    i_can_node_model.tx(4'h0);
    #1 chk(tx_load_o, 1'b1);
    chk(tx_center_o, 4'h4);
    i_can_node_model.tx(4'h4);
    rd(ca(3, 4));
    chk(v & 32'h8, 32'h8);
    i_can_node_model.tx(4'h0);
    #1 chk(tx_center_o, 4'h6);
    results();
  end
endmodule
